/* src/ubt_burst_trailer.sv */
// burst trailer assembly ahead of the pseudowire steer
`timescale 1ns/1ns
`include "ubt_defines.svh"
module ubt_burst_trailer #(
    parameter int NCH = 4,
    parameter int CHW = 2,
    parameter int VND_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bs_valid,
    output logic bs_ready,
    input wire logic [CHW-1:0] bs_chan,
    input wire logic [3:0] bs_interval_usage_code,
    input wire logic bs_no_payload,
    input wire logic pl_valid,
    output logic pl_ready,
    input wire logic [7:0] pl_data,
    input wire logic pl_last,
    input wire logic cw_valid,
    input wire ubt_pkg::ubt_cls_t cw_class,
    input wire logic [7:0] cw_iters,
    input wire logic cw_pre_fail,
    input wire logic cw_post_fail,
    input wire logic [7:0] modulation_error_ratio,
    input wire logic [7:0] pwr_err,
    input wire logic [15:0] frq_err,
    input wire logic [31:0] tim_err,
    input wire logic tim_vld,
    input wire logic pwr_vld,
    input wire logic frq_vld,
    input wire logic vendor_extension_flag,
    input wire logic [23:0] vendor_registry_identifier,
    input wire logic [7:0] vnd_len,
    input wire logic vnd_wr,
    input wire logic [4:0] vnd_addr,
    input wire logic [7:0] vnd_wdata,
    input wire logic extract_en,
    input wire logic [NCH*32-1:0] rng_sess_cfg,
    input wire logic [NCH*32-1:0] dat_sess_cfg,
    output logic rng_valid,
    input wire logic rng_ready,
    output logic [7:0] rng_data,
    output logic rng_sop,
    output logic rng_eop,
    output ubt_pkg::ubt_sess_t rng_sess,
    output logic dat_valid,
    input wire logic dat_ready,
    output logic [7:0] dat_data,
    output logic dat_sop,
    output logic dat_eop,
    output ubt_pkg::ubt_sess_t dat_sess
);
    import ubt_pkg::*;

    // ***********************************************************
    // declarations
    // ***********************************************************
    ubt_state_t state_r;
    logic [5:0] idx_r, len_r, last_idx, voff, vcnt_r;
    logic [CHW-1:0] chan_r;
    logic [3:0] usage_r;
    logic vflag_r, tvld_r, pvld_r, fvld_r;
    logic [7:0] mer_r, pwr_r;
    logic [15:0] frq_r;
    logic [31:0] tim_r;
    logic [23:0] vid_r;
    logic [7:0] vnd_mem [VND_DEPTH];
    logic [15:0] sum_r [3];
    logic [7:0] ncw_r [3];
    logic [7:0] pass_r [3];
    logic [7:0] fail_r [3];
    logic bs_fire, pl_fire, trl_go, tu_valid, tu_ready, tu_last, tu_fire;
    logic [7:0] tu_data, trl_byte;

    function automatic logic [7:0] avg_of(input logic [15:0] sum,
                                          input logic [7:0] n);
        logic [15:0] q;
        q = 16'h0000;
        if (n != 8'h00) begin
            q = sum / {8'h00, n};
        end
        return (q > 16'h00FF) ? 8'hFF : q[7:0];
    endfunction

    assign bs_ready = (state_r == ST_IDLE);
    assign bs_fire = bs_valid && bs_ready;
    assign pl_ready = (state_r == ST_PAY) && tu_ready;
    assign pl_fire = pl_valid && pl_ready;
    assign trl_go = (bs_fire && bs_no_payload) || (pl_fire && pl_last);
    assign tu_fire = tu_valid && tu_ready;

    // ***********************************************************
    // burst sequencing
    // ***********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (bs_fire) begin
                        state_r <= bs_no_payload ? ST_TRL : ST_PAY;
                    end
                end
                ST_PAY: begin
                    if (pl_fire && pl_last) begin
                        state_r <= ST_TRL;
                    end
                end
                ST_TRL: begin
                    if (tu_fire && tu_last) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_r <= `UBT_IDX_RST;
        end else if (bs_fire) begin
            idx_r <= `UBT_IDX_RST;
        end else if (state_r == ST_TRL && tu_fire) begin
            idx_r <= idx_r + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_r <= '0;
            usage_r <= 4'h0;
        end else if (bs_fire) begin
            chan_r <= bs_chan;
            usage_r <= bs_interval_usage_code;
        end
    end

    // ***********************************************************
    // measurements caught as the trailer starts
    // ***********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mer_r <= 8'h00;
            pwr_r <= 8'h00;
            frq_r <= 16'h0000;
            tim_r <= 32'h0000_0000;
            tvld_r <= 1'b0;
            pvld_r <= 1'b0;
            fvld_r <= 1'b0;
            vflag_r <= 1'b0;
            vid_r <= 24'h00_0000;
            len_r <= 6'h00;
        end else if (trl_go) begin
            mer_r <= modulation_error_ratio;
            pwr_r <= pwr_err;
            frq_r <= frq_err;
            tim_r <= tim_err;
            tvld_r <= tim_vld;
            pvld_r <= pwr_vld;
            fvld_r <= frq_vld;
            vflag_r <= vendor_extension_flag;
            vid_r <= vendor_registry_identifier;
            // oversized lengths are clipped to the cap
            len_r <= (vnd_len > {2'h0, `UBT_VND_MAX}) ? `UBT_VND_MAX
                : vnd_len[5:0];
        end
    end

    always_ff @(posedge clk) begin
        if (vnd_wr) begin
            vnd_mem[vnd_addr] <= vnd_wdata;
        end
    end

    // ***********************************************************
    // codeword statistics per length class
    // ***********************************************************
    for (genvar c = 0; c < 3; c++) begin : g_cls
        localparam logic [7:0] CAP = (c == 0) ? `UBT_CAP_LONG
            : `UBT_CAP_SHORT;
        logic hit;
        logic [16:0] s;
        assign hit = cw_valid && (state_r == ST_PAY) &&
            (cw_class == 2'(c));
        assign s = {1'b0, sum_r[c]} + {9'h000, cw_iters};

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sum_r[c] <= `UBT_SUM_RST;
                ncw_r[c] <= `UBT_CNT_RST;
                pass_r[c] <= `UBT_CNT_RST;
                fail_r[c] <= `UBT_CNT_RST;
            end else if (bs_fire) begin
                sum_r[c] <= `UBT_SUM_RST;
                ncw_r[c] <= `UBT_CNT_RST;
                pass_r[c] <= `UBT_CNT_RST;
                fail_r[c] <= `UBT_CNT_RST;
            end else if (hit) begin
                if (ncw_r[c] != 8'hFF) begin
                    ncw_r[c] <= ncw_r[c] + 8'h01;
                    sum_r[c] <= s[16] ? 16'hFFFF : s[15:0];
                end
                if (cw_pre_fail && !cw_post_fail && pass_r[c] != CAP) begin
                    pass_r[c] <= pass_r[c] + 8'h01;
                end
                if (cw_post_fail && fail_r[c] != CAP) begin
                    fail_r[c] <= fail_r[c] + 8'h01;
                end
            end
        end

        property p_pass_cnt;
            @(posedge clk) disable iff (!rst_n)
            hit && !bs_fire && cw_pre_fail && !cw_post_fail &&
                pass_r[c] < CAP |=> pass_r[c] == $past(pass_r[c]) + 8'h01;
        endproperty
        a_pass_cnt: assert property (p_pass_cnt)
            else $error("recovered codeword count missed");

        property p_fail_cap;
            @(posedge clk) disable iff (!rst_n)
            fail_r[c] <= CAP;
        endproperty
        a_fail_cap: assert property (p_fail_cap)
            else $error("failed codeword count over field width");
    end

    // ***********************************************************
    // trailer byte selection, MSB first
    // ***********************************************************
    assign voff = idx_r - `UBT_B_VDAT;
    assign last_idx = vflag_r ? (`UBT_B_VDAT + len_r - 6'h01)
        : `UBT_B_FIX_LAST;

    always_comb begin
        trl_byte = 8'h00;
        case (idx_r)
            `UBT_B_STAT: begin
                trl_byte[`UBT_ST_TYPE] = 1'b1;
                trl_byte[`UBT_ST_VND] = vflag_r;
            end
            `UBT_B_BSTAT: begin
                trl_byte[`UBT_BS_TIM] = tvld_r;
                trl_byte[`UBT_BS_PWR] = pvld_r;
                trl_byte[`UBT_BS_FRQ] = fvld_r;
            end
            `UBT_B_IT_L: trl_byte = avg_of(sum_r[0], ncw_r[0]);
            `UBT_B_IT_M: trl_byte = avg_of(sum_r[1], ncw_r[1]);
            `UBT_B_IT_S: trl_byte = avg_of(sum_r[2], ncw_r[2]);
            `UBT_B_PS_L: trl_byte = pass_r[0];
            `UBT_B_FL_L: trl_byte = fail_r[0];
            `UBT_B_CNT_M: trl_byte = {pass_r[1][3:0], fail_r[1][3:0]};
            `UBT_B_CNT_S: trl_byte = {pass_r[2][3:0], fail_r[2][3:0]};
            `UBT_B_MER: trl_byte = mer_r;
            `UBT_B_PWR: trl_byte = pwr_r;
            `UBT_B_FRQ: trl_byte = frq_r[15:8];
            `UBT_B_FRQ_LO: trl_byte = frq_r[7:0];
            `UBT_B_TIM: trl_byte = tim_r[31:24];
            `UBT_B_TIM_2: trl_byte = tim_r[23:16];
            `UBT_B_TIM_1: trl_byte = tim_r[15:8];
            `UBT_B_FIX_LAST: trl_byte = tim_r[7:0];
            `UBT_B_VID: trl_byte = vid_r[23:16];
            `UBT_B_VID_1: trl_byte = vid_r[15:8];
            `UBT_B_VID_0: trl_byte = vid_r[7:0];
            `UBT_B_VLEN: trl_byte = {2'h0, len_r};
            default: begin
                if (idx_r >= `UBT_B_VDAT) begin
                    trl_byte = vnd_mem[voff[4:0]];
                end
            end
        endcase
    end

    assign tu_valid = (state_r == ST_PAY) ? pl_valid : (state_r == ST_TRL);
    assign tu_data = (state_r == ST_PAY) ? pl_data : trl_byte;
    assign tu_last = (state_r == ST_TRL) && (idx_r == last_idx);

    ubt_pw_steer #(
        .NCH(NCH),
        .CHW(CHW)
    ) u_steer (
        .clk(clk),
        .rst_n(rst_n),
        .tu_valid(tu_valid),
        .tu_ready(tu_ready),
        .tu_data(tu_data),
        .tu_last(tu_last),
        .tu_chan(chan_r),
        .tu_usage(usage_r),
        .extract_en(extract_en),
        .rng_sess_cfg(rng_sess_cfg),
        .dat_sess_cfg(dat_sess_cfg),
        .rng_valid(rng_valid),
        .rng_ready(rng_ready),
        .rng_data(rng_data),
        .rng_sop(rng_sop),
        .rng_eop(rng_eop),
        .rng_sess(rng_sess),
        .dat_valid(dat_valid),
        .dat_ready(dat_ready),
        .dat_data(dat_data),
        .dat_sop(dat_sop),
        .dat_eop(dat_eop),
        .dat_sess(dat_sess)
    );

    // ***********************************************************
    // checks
    // ***********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vcnt_r <= 6'h00;
        end else if (bs_fire) begin
            vcnt_r <= 6'h00;
        end else if (tu_fire && state_r == ST_TRL &&
                     idx_r >= `UBT_B_VDAT) begin
            vcnt_r <= vcnt_r + 6'h01;
        end
    end

    property p_len_cap;
        @(posedge clk) disable iff (!rst_n)
        len_r <= `UBT_VND_MAX;
    endproperty
    a_len_cap: assert property (p_len_cap)
        else $error("vendor length above cap");

    property p_vnd_omit;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && state_r == ST_TRL && !vflag_r |->
            idx_r <= `UBT_B_FIX_LAST;
    endproperty
    a_vnd_omit: assert property (p_vnd_omit)
        else $error("vendor byte sent with flag clear");

    property p_vnd_exact;
        @(posedge clk) disable iff (!rst_n)
        state_r == ST_IDLE && $past(state_r) == ST_TRL |->
            vcnt_r == (vflag_r ? len_r : 6'h00);
    endproperty
    a_vnd_exact: assert property (p_vnd_exact)
        else $error("vendor content count differs from length");

    property p_stat;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && state_r == ST_TRL && idx_r == `UBT_B_STAT |->
            tu_data == {2'h0, 1'b1, 4'h0, vflag_r};
    endproperty
    a_stat: assert property (p_stat)
        else $error("status byte wrong");

    property p_bstat;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && state_r == ST_TRL && idx_r == `UBT_B_BSTAT |->
            tu_data == {5'h00, tvld_r, pvld_r, fvld_r};
    endproperty
    a_bstat: assert property (p_bstat)
        else $error("burst status validity bits wrong");

    property p_rsv;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && state_r == ST_TRL &&
            (idx_r == `UBT_B_RSV0 || idx_r == `UBT_B_RSV1) |->
            tu_data == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved trailer byte not zero");

    property p_avg_zero;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && state_r == ST_TRL && idx_r == `UBT_B_IT_L &&
            ncw_r[0] == 8'h00 |-> tu_data == 8'h00;
    endproperty
    a_avg_zero: assert property (p_avg_zero)
        else $error("average reported with no codewords");

    c_vnd: cover property (@(posedge clk) disable iff (!rst_n)
        tu_fire && tu_last && vflag_r && len_r == `UBT_VND_MAX);
    c_nopay: cover property (@(posedge clk) disable iff (!rst_n)
        bs_fire && bs_no_payload);
endmodule // ubt_burst_trailer

/* src/ubt_defines.svh */
// constants for the burst trailer framer and ranging steer
`ifndef UBT_DEFINES_SVH
`define UBT_DEFINES_SVH

// ***********************************************************
// codes and limits
// ***********************************************************
`define UBT_USAGE_RNG_A 4'h3
`define UBT_USAGE_RNG_B 4'h4
`define UBT_VND_MAX 6'h20
`define UBT_CLS_LONG 2'h0
`define UBT_CLS_MED 2'h1
`define UBT_CLS_SHORT 2'h2
`define UBT_CAP_LONG 8'hFF
`define UBT_CAP_SHORT 8'h0F

// ***********************************************************
// trailer byte offsets
// ***********************************************************
`define UBT_B_STAT 6'h00
`define UBT_B_BSTAT 6'h01
`define UBT_B_IT_L 6'h02
`define UBT_B_IT_M 6'h03
`define UBT_B_IT_S 6'h04
`define UBT_B_PS_L 6'h05
`define UBT_B_FL_L 6'h06
`define UBT_B_CNT_M 6'h07
`define UBT_B_CNT_S 6'h08
`define UBT_B_RSV0 6'h09
`define UBT_B_RSV1 6'h0A
`define UBT_B_MER 6'h0B
`define UBT_B_PWR 6'h0C
`define UBT_B_FRQ 6'h0D
`define UBT_B_FRQ_LO 6'h0E
`define UBT_B_TIM 6'h0F
`define UBT_B_TIM_2 6'h10
`define UBT_B_TIM_1 6'h11
`define UBT_B_FIX_LAST 6'h12
`define UBT_B_VID 6'h13
`define UBT_B_VID_1 6'h14
`define UBT_B_VID_0 6'h15
`define UBT_B_VLEN 6'h16
`define UBT_B_VDAT 6'h17

// ***********************************************************
// status bit positions and reset values
// ***********************************************************
`define UBT_ST_TYPE 5
`define UBT_ST_VND 0
`define UBT_BS_TIM 2
`define UBT_BS_PWR 1
`define UBT_BS_FRQ 0
`define UBT_SUM_RST 16'h0000
`define UBT_CNT_RST 8'h00
`define UBT_IDX_RST 6'h00

`endif

/* src/ubt_pkg.sv */
// types for the burst trailer framer and ranging steer
package ubt_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_PAY, ST_TRL} ubt_state_t;
    typedef logic [1:0] ubt_cls_t;
    typedef logic [31:0] ubt_sess_t;
endpackage

/* src/ubt_pw_steer.sv */
// routes transmission units onto data or ranging pseudowires
`timescale 1ns/1ns
`include "ubt_defines.svh"
module ubt_pw_steer #(
    parameter int NCH = 4,
    parameter int CHW = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tu_valid,
    output logic tu_ready,
    input wire logic [7:0] tu_data,
    input wire logic tu_last,
    input wire logic [CHW-1:0] tu_chan,
    input wire logic [3:0] tu_usage,
    input wire logic extract_en,
    input wire logic [NCH*32-1:0] rng_sess_cfg,
    input wire logic [NCH*32-1:0] dat_sess_cfg,
    output logic rng_valid,
    input wire logic rng_ready,
    output logic [7:0] rng_data,
    output logic rng_sop,
    output logic rng_eop,
    output ubt_pkg::ubt_sess_t rng_sess,
    output logic dat_valid,
    input wire logic dat_ready,
    output logic [7:0] dat_data,
    output logic dat_sop,
    output logic dat_eop,
    output ubt_pkg::ubt_sess_t dat_sess
);
    import ubt_pkg::*;

    logic first_r, route_r, o_v_r, o_rng_r, o_sop_r, o_eop_r;
    logic [7:0] o_data_r;
    ubt_sess_t o_sess_r;
    logic is_rng_code, route_now, tu_fire, out_ready;

    assign is_rng_code = (tu_usage == `UBT_USAGE_RNG_A) ||
        (tu_usage == `UBT_USAGE_RNG_B);
    // route frozen at first byte so a unit never changes pipe
    assign route_now = first_r ? (extract_en && is_rng_code)
        : route_r;
    assign out_ready = o_rng_r ? rng_ready : dat_ready;
    assign tu_ready = !o_v_r || out_ready;
    assign tu_fire = tu_valid && tu_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_r <= 1'b1;
            route_r <= 1'b0;
        end else if (tu_fire) begin
            first_r <= tu_last;
            route_r <= route_now;
        end
    end

    // ***********************************************************
    // output stage, unit bytes unchanged on either pipe
    // ***********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            o_v_r <= 1'b0;
            o_rng_r <= 1'b0;
            o_sop_r <= 1'b0;
            o_eop_r <= 1'b0;
            o_data_r <= 8'h00;
            o_sess_r <= 32'h0000_0000;
        end else if (tu_ready) begin
            o_v_r <= tu_valid;
            if (tu_valid) begin
                o_rng_r <= route_now;
                o_data_r <= tu_data;
                o_sop_r <= first_r;
                o_eop_r <= tu_last;
                if (first_r) begin
                    o_sess_r <= route_now ? rng_sess_cfg[tu_chan*32 +: 32]
                        : dat_sess_cfg[tu_chan*32 +: 32];
                end
            end
        end
    end

    assign rng_valid = o_v_r && o_rng_r;
    assign dat_valid = o_v_r && !o_rng_r;
    assign rng_data = o_data_r;
    assign dat_data = o_data_r;
    assign rng_sop = o_sop_r;
    assign dat_sop = o_sop_r;
    assign rng_eop = o_eop_r;
    assign dat_eop = o_eop_r;
    assign rng_sess = o_sess_r;
    assign dat_sess = o_sess_r;

    // ***********************************************************
    // checks
    // ***********************************************************
    property p_rng_route;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && first_r && extract_en && is_rng_code |=> rng_valid;
    endproperty
    a_rng_route: assert property (p_rng_route)
        else $error("ranging code burst not on ranging pipe");

    property p_no_data;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && first_r && extract_en && is_rng_code |=> !dat_valid;
    endproperty
    a_no_data: assert property (p_no_data)
        else $error("ranging code burst on data pipe");

    property p_idle_off;
        @(posedge clk) disable iff (!rst_n)
        tu_fire && first_r && !extract_en |=> !rng_valid;
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("ranging pipe used while extraction off");

    property p_one_unit;
        @(posedge clk) disable iff (!rst_n)
        rng_valid && rng_ready && rng_eop |=> !rng_valid || rng_sop;
    endproperty
    a_one_unit: assert property (p_one_unit)
        else $error("ranging packet continues past unit end");

    property p_no_split;
        @(posedge clk) disable iff (!rst_n)
        rng_valid && rng_ready && !rng_eop |=> !(dat_valid || rng_sop);
    endproperty
    a_no_split: assert property (p_no_split)
        else $error("ranging unit broken before its end");

    c_rng_pkt: cover property (@(posedge clk) disable iff (!rst_n)
        rng_valid && rng_ready && rng_eop);
    c_dat_pkt: cover property (@(posedge clk) disable iff (!rst_n)
        dat_valid && dat_ready && dat_eop);
endmodule // ubt_pw_steer

/* testbench/ubt_burst_trailer_tb.sv */
// bench for the burst trailer framer and ranging steer
`timescale 1ns/1ns
module ubt_burst_trailer_tb;
import ubt_pkg::*;
logic clk=0,rst_n=0,bs_valid=0,bs_no_payload=0,pl_valid=0,pl_last=0;
logic cw_valid=0,cw_pre_fail=0,cw_post_fail=0,tim_vld=0,pwr_vld=0;
logic frq_vld=0,vendor_extension_flag=0,vnd_wr=0,extract_en=0,p;
logic bs_ready,pl_ready,rng_valid,dat_valid,rng_ready,dat_ready;
logic rng_sop,rng_eop,dat_sop,dat_eop;
logic [1:0] bs_chan=0;
ubt_cls_t cw_class=0;
logic [3:0] bs_interval_usage_code=0;
logic [4:0] vnd_addr=0;
logic [7:0] pl_data=0,cw_iters=0,modulation_error_ratio=0,pwr_err=0;
logic [7:0] vnd_len=0,vnd_wdata=0,rng_data,dat_data,vm[32];
logic [15:0] frq_err=0;
logic [23:0] vendor_registry_identifier=0;
logic [31:0] tim_err=0,x=32'hFC8935E5,ss;
logic [127:0] rng_sess_cfg=0,dat_sess_cfg=0;
ubt_sess_t rng_sess,dat_sess;
logic [42:0] q[$],g;
int n_mismatch=0,check_count=0,cyc=0;
always #5 clk=~clk;
ubt_burst_trailer i_ubt_burst_trailer(.clk(clk),.rst_n(rst_n),
    .bs_valid(bs_valid),.bs_ready(bs_ready),.bs_chan(bs_chan),
    .bs_interval_usage_code(bs_interval_usage_code),
    .bs_no_payload(bs_no_payload),.pl_valid(pl_valid),
    .pl_ready(pl_ready),.pl_data(pl_data),.pl_last(pl_last),
    .cw_valid(cw_valid),.cw_class(cw_class),.cw_iters(cw_iters),
    .cw_pre_fail(cw_pre_fail),.cw_post_fail(cw_post_fail),
    .modulation_error_ratio(modulation_error_ratio),
    .pwr_err(pwr_err),.frq_err(frq_err),.tim_err(tim_err),
    .tim_vld(tim_vld),.pwr_vld(pwr_vld),.frq_vld(frq_vld),
    .vendor_extension_flag(vendor_extension_flag),
    .vendor_registry_identifier(vendor_registry_identifier),
    .vnd_len(vnd_len),.vnd_wr(vnd_wr),.vnd_addr(vnd_addr),
    .vnd_wdata(vnd_wdata),.extract_en(extract_en),
    .rng_sess_cfg(rng_sess_cfg),.dat_sess_cfg(dat_sess_cfg),
    .rng_valid(rng_valid),.rng_ready(rng_ready),.rng_data(rng_data),
    .rng_sop(rng_sop),.rng_eop(rng_eop),.rng_sess(rng_sess),
    .dat_valid(dat_valid),.dat_ready(dat_ready),.dat_data(dat_data),
    .dat_sop(dat_sop),.dat_eop(dat_eop),.dat_sess(dat_sess));
ubt_mac_model i_ubt_mac_model(.clk(clk),.rst_n(rst_n),
    .rng_ready(rng_ready),.dat_ready(dat_ready));
function automatic logic [31:0] rnd();
    repeat (32) x={x[30:0],x[31]^x[21]^x[1]^x[0]};
    return x;
endfunction
function automatic logic [7:0] avg(logic [15:0] s,logic [7:0] k);
    logic [15:0] a;
    a=(k==0)?16'h0:s/k;
    return (a>16'hFF)?8'hFF:a[7:0];
endfunction
task automatic chk(logic [42:0] got,logic [42:0] exp);
    check_count++;
    if (got!==exp) begin
        n_mismatch++;
        $display("[FAIL] t=%0t got %h exp %h",$time,got,exp);
    end
endtask
task automatic put(logic [7:0] b);
    q.push_back({p,2'b00,b,ss});
endtask
task results;
    $display("checks %0d mismatches %0d",check_count,n_mismatch);
    if (n_mismatch==0 && check_count>0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task automatic burst(int n,int cd);
    logic [31:0] c,d,e,f,w;
    logic [3:0] u;
    logic [7:0] pb[4],k[3],pa[3],fa[3];
    logic [15:0] s[3];
    logic [151:0] t;
    int vl;
    c=rnd();
    d=rnd();
    e=rnd();
    f=rnd();
    u=(cd>15)?c[5:2]:cd[3:0];
    p=(c[6]||cd<16)&&(u==3||u==4);
    ss=p?rng_sess_cfg[32*c[1:0]+:32]:dat_sess_cfg[32*c[1:0]+:32];
    k='{0,0,0};
    pa='{0,0,0};
    fa='{0,0,0};
    s='{0,0,0};
    @(posedge clk);
    bs_valid<=1;
    bs_chan<=c[1:0];
    bs_interval_usage_code<=u;
    bs_no_payload<=(n==0);
    extract_en<=c[6]||cd<16;
    {vendor_extension_flag,tim_vld,pwr_vld,frq_vld}<=c[10:7];
    vnd_len<={2'b00,c[16:11]};
    {modulation_error_ratio,pwr_err,frq_err}<=d;
    vendor_registry_identifier<=e[23:0];
    tim_err<=f;
    @(posedge clk);
    chk(bs_ready,1'b1);
    bs_valid<=0;
    @(posedge clk);
    chk(bs_ready,1'b0);
    for (int i=0;i<n;i++) begin
        w=rnd();
        pb[i]=w[31:24];
        cw_valid<=1;
        {cw_post_fail,cw_pre_fail,cw_iters,cw_class}<=w[11:0];
        if (w[1:0]!=2'h3) begin
            s[w[1:0]]+=w[9:2];
            k[w[1:0]]++;
            pa[w[1:0]]+=(w[10]&&!w[11]);
            fa[w[1:0]]+=w[11];
        end
        @(posedge clk);
    end
    cw_valid<=0;
    for (int i=0;i<n;i++) put(pb[i]);
    t={8'h20|c[10],5'h0,c[9:7],avg(s[0],k[0]),avg(s[1],k[1]),
       avg(s[2],k[2]),pa[0],fa[0],pa[1][3:0],fa[1][3:0],pa[2][3:0],
       fa[2][3:0],16'h0,d,f};
    for (int i=0;i<19;i++)
        put(t[151-8*i-:8]);
    if (c[10]) begin
        vl=(c[16:11]>32)?32:c[16:11];
        for (int i=0;i<3;i++) put(e[23-8*i-:8]);
        put(8'(vl));
        for (int i=0;i<vl;i++) put(vm[i]);
    end
    q[0][41]=1'b1;
    q[$][40]=1'b1;
    for (int i=0;i<n;i++) begin
        pl_valid<=1;
        pl_data<=pb[i];
        pl_last<=(i==n-1);
        @(posedge clk);
        while (!pl_ready) @(posedge clk);
    end
    pl_valid<=0;
    while (q.size()>0) @(posedge clk);
endtask
always @(posedge clk) begin
    cyc++;
    if (cyc>30000) begin
        n_mismatch++;
        results;
    end
end
always @(posedge clk) begin
    if (rst_n && (rng_valid&&rng_ready || dat_valid&&dat_ready)) begin
        g=(rng_valid&&rng_ready)?{1'b1,rng_sop,rng_eop,rng_data,rng_sess}
          :{1'b0,dat_sop,dat_eop,dat_data,dat_sess};
        chk(g,q.size()?q.pop_front():~g);
    end
end
initial begin
    repeat (3) @(posedge clk);
    rst_n<=1;
    rng_sess_cfg<={rnd(),rnd(),rnd(),rnd()};
    dat_sess_cfg<={rnd(),rnd(),rnd(),rnd()};
    for (int i=0;i<32;i++) begin
        @(posedge clk);
        vm[i]=8'(rnd());
        vnd_wr<=1;
        vnd_addr<=5'(i);
        vnd_wdata<=vm[i];
    end
    @(posedge clk);
    vnd_wr<=0;
    burst(0,3);
    burst(4,4);
    burst(1,3);
    for (int i=0;i<60;i++) burst(int'(rnd()%5),16);
    results;
end
endmodule // ubt_burst_trailer_tb

/* testbench/ubt_mac_model.sv */
// core mac stand-in taking packets with periodic stalls
`timescale 1ns/1ns
module ubt_mac_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic rng_ready,
    output logic dat_ready
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            rng_ready <= 1'b0;
            dat_ready <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            rng_ready <= cnt_r[2:0] != 3'h5;
            dat_ready <= cnt_r != 4'h9 && cnt_r != 4'h2;
        end
    end
endmodule // ubt_mac_model
